// ### design/erc_top.sv
// Error report control register bank: device enable plus five component
// status/control and mask register pairs behind a classic Wishbone slave.
// Assumes error strobes and class/severity come from logic on CLK.
`timescale 1ns/1ps

module erc_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  input wire logic [erc_pkg::NCOMP-1:0] ERR_VALID,
  input wire logic [erc_pkg::NCOMP*erc_pkg::CLASS_IDX_W-1:0] ERR_CLASS,
  input wire logic [erc_pkg::NCOMP*erc_pkg::SEV_W-1:0] ERR_SEV,
  output logic [erc_pkg::NCOMP-1:0] LOG_CAPTURE,
  output logic [erc_pkg::NCOMP-1:0] MSG_SEND,
  output logic [erc_pkg::NCOMP-1:0] LOG_CLEAR,
  output logic DEV_ENABLE
);

  // ==========================================================================
  // Bus front end
  erc_acc_if acc ();

  erc_wb_slave u_wb (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .cyc(WB_CYC_I),
    .stb(WB_STB_I),
    .we(WB_WE_I),
    .adr(WB_ADR_I),
    .dat_i(WB_DAT_I),
    .sel(WB_SEL_I),
    .ack(WB_ACK_O),
    .dat_o(WB_DAT_O),
    .acc(acc)
  );

  // ==========================================================================
  // Decode
  // Unmapped addresses still get ack; they read zero and drop writes.
  logic [7:0] rel;
  logic hit_dev;
  logic in_comp;
  logic [4:0] comp_idx;
  logic is_mask;

  assign rel = acc.addr - erc_pkg::ADDR_COMP_BASE;
  assign hit_dev = acc.addr[7:2] == erc_pkg::ADDR_DEV_ENABLE[7:2];
  assign comp_idx = rel[7:erc_pkg::COMP_STRIDE_LOG2];
  assign in_comp = (acc.addr >= erc_pkg::ADDR_COMP_BASE) && (comp_idx < 5'(erc_pkg::NCOMP));
  assign is_mask = rel[2] == erc_pkg::OFS_MASK[2];

  // ==========================================================================
  // Device enable
  logic dev_en;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dev_en <= erc_pkg::DEV_EN_RST;
    end else if (acc.wr && hit_dev && acc.sel[0]) begin
      dev_en <= acc.wdata[erc_pkg::EN_POS];
    end
  end

  assign DEV_ENABLE = dev_en;

  // ==========================================================================
  // Component register pairs
  logic [erc_pkg::NCOMP-1:0][1:0] sta_v;
  logic [erc_pkg::NCOMP-1:0][1:0] dis_v;
  logic [erc_pkg::NCOMP-1:0][31:0] mask_v;
  logic [erc_pkg::NCOMP-1:0] clear_v;

  for (genvar i = 0; i < erc_pkg::NCOMP; i++) begin : g_comp
    logic hit;
    logic [1:0] dis;
    logic [erc_pkg::NCLASS-1:0] class_mask;
    logic [erc_pkg::NSEV-1:0] msg_mask;
    logic [erc_pkg::NSEV-1:0] cap_mask;
    logic [31:0] img;
    logic [31:0] next_img;
    erc_pkg::erc_sta_t sta;

    assign hit = in_comp && (comp_idx == 5'(i));
    assign img = {6'h00, class_mask, 2'h0, msg_mask, cap_mask};
    assign next_img = erc_pkg::wr_merge(img, acc.wdata, acc.sel);
    // Only the all-ones pattern clears; zeros and other patterns leave the status alone.
    assign clear_v[i] = acc.wr && hit && !is_mask && acc.sel[0] &&
                        (acc.wdata[erc_pkg::STA_MSB:erc_pkg::STA_LSB] ==
                         erc_pkg::STA_CLEAR_CMD);

    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        dis <= erc_pkg::DIS_RST;
      end else if (acc.wr && hit && !is_mask && acc.sel[0]) begin
        dis <= acc.wdata[erc_pkg::DIS_MSB:erc_pkg::DIS_LSB];
      end
    end

    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        class_mask <= erc_pkg::CLASS_MASK_RST;
        msg_mask <= erc_pkg::SEV_MASK_RST;
        cap_mask <= erc_pkg::SEV_MASK_RST;
      end else if (acc.wr && hit && is_mask) begin
        class_mask <= next_img[erc_pkg::CLASS_MSB:erc_pkg::CLASS_LSB];
        msg_mask <= next_img[erc_pkg::SEVMSG_MSB:erc_pkg::SEVMSG_LSB];
        cap_mask <= next_img[erc_pkg::SEVLOG_MSB:erc_pkg::SEVLOG_LSB];
      end
    end

    erc_comp u_comp (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .dev_en(dev_en),
      .dis(dis),
      .class_mask(class_mask),
      .msg_mask(msg_mask),
      .cap_mask(cap_mask),
      .err_valid(ERR_VALID[i]),
      .err_class(ERR_CLASS[i*erc_pkg::CLASS_IDX_W +: erc_pkg::CLASS_IDX_W]),
      .err_sev(ERR_SEV[i*erc_pkg::SEV_W +: erc_pkg::SEV_W]),
      .sta_clear(clear_v[i]),
      .sta(sta),
      .log_capture(LOG_CAPTURE[i]),
      .msg_send(MSG_SEND[i]),
      .log_clear(LOG_CLEAR[i])
    );

    assign sta_v[i] = sta;
    assign dis_v[i] = dis;
    assign mask_v[i] = img;
  end

  // ==========================================================================
  // Read mux
  always_comb begin
    acc.rdata = 32'h0000_0000;
    if (hit_dev) begin
      acc.rdata[erc_pkg::EN_POS] = dev_en;
    end
    for (int k = 0; k < erc_pkg::NCOMP; k++) begin
      if (in_comp && comp_idx == 5'(k)) begin
        acc.rdata = is_mask ? mask_v[k] : {28'h0000000, dis_v[k], sta_v[k]};
      end
    end
  end

  // ==========================================================================
  // Checks
  a_dev_en_write: assert property (@(posedge CLK) disable iff (!NRST)
    (acc.wr && hit_dev && acc.sel[0]) |=> dev_en == $past(acc.wdata[erc_pkg::EN_POS]))
    else $error("device enable write lost");
  a_dev_off_silent: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && !dev_en) |=> (MSG_SEND == '0) && (LOG_CAPTURE == '0))
    else $error("report or log while device disabled");
  a_zero_write_idle: assert property (@(posedge CLK) disable iff (!NRST)
    (acc.wr && !is_mask && in_comp &&
     acc.wdata[erc_pkg::STA_MSB:erc_pkg::STA_LSB] == 2'h0) |-> clear_v == '0)
    else $error("zero write cleared status");
  a_read_status: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O && in_comp && !is_mask) |=>
      WB_DAT_O[1:0] == $past(sta_v[comp_idx]))
    else $error("status read wrong");

  c_dev_enable: cover property (@(posedge CLK) disable iff (!NRST)
    acc.wr && hit_dev && acc.wdata[erc_pkg::EN_POS]);
  c_status_clear: cover property (@(posedge CLK) disable iff (!NRST)
    clear_v != '0);

endmodule

// ### design/erc_pkg.sv
// Constants, field layout and status codes of the error report control block.
// Assumes a 32-bit classic Wishbone register port and one device clock.
//
// Notes on behaviour
// - Every error control and status register leaves reset in its disabled state.
// - Once enabled, every error is unmasked unless software has set its mask bits.
// - The device enable bit 0 gates both report messages and log capture for all components.
// - With the device enable at zero no report messages go out, from the cycle after it clears.
// - Clearing the device enable leaves logged component errors pending and untouched.
// - An enabled, unmasked error captures a log per its gates, and sends a message per its gate only along with that capture.
// - The device enable bit resets to zero.
// - Each of the five components has its own status/control and mask register pair.
// - Status 00 clear, 01 logged without message, 10 invalid, 11 logged and reported.
// - Writing ones to the status field returns it to zero and invalidates the log.
// - The log is overwritten by a new error only once the status field is clear.
// - Writing zeros to the status field changes neither the field nor the log.
// - A new log from the clear state moves status to 01, or to 11 when a message is raised.

package erc_pkg;

  // ==========================================================================
  // Map
  localparam int NCOMP = 5;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_DEV_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_COMP_BASE = 8'h10;
  localparam int COMP_STRIDE_LOG2 = 3;
  localparam logic [2:0] OFS_STATUS_CTRL = 3'h0;
  localparam logic [2:0] OFS_MASK = 3'h4;

  // ==========================================================================
  // Fields
  localparam int EN_POS = 0;
  localparam int STA_LSB = 0;
  localparam int STA_MSB = 1;
  localparam int DIS_LSB = 2;
  localparam int DIS_MSB = 3;
  localparam int DIS_LOG_POS = 0;
  localparam int DIS_MSG_POS = 1;
  localparam int SEVLOG_LSB = 0;
  localparam int SEVLOG_MSB = 6;
  localparam int SEVMSG_LSB = 7;
  localparam int SEVMSG_MSB = 13;
  localparam int CLASS_LSB = 16;
  localparam int CLASS_MSB = 25;
  localparam int NCLASS = 10;
  localparam int NSEV = 7;
  localparam int CLASS_IDX_W = 4;
  localparam int SEV_W = 3;

  // ==========================================================================
  // Reset values and codes
  localparam logic DEV_EN_RST = 1'b0;
  localparam logic [1:0] DIS_RST = 2'h3;
  localparam logic [NCLASS-1:0] CLASS_MASK_RST = 10'h000;
  localparam logic [NSEV-1:0] SEV_MASK_RST = 7'h00;
  localparam logic [1:0] STA_CLEAR_CMD = 2'h3;

  typedef enum logic [1:0] {
    STA_CLEAR = 2'h0,
    STA_LOGGED = 2'h1,
    STA_INVALID = 2'h2,
    STA_REPORTED = 2'h3
  } erc_sta_t;

  // Byte-lane merge of a write into a register image.
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] sel);
    logic [31:0] be;
    be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~be) | (data & be);
  endfunction

endpackage

// ### design/erc_acc_if.sv
// Register access path between the bus front end and the register bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps

interface erc_acc_if;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] sel;
  logic [31:0] rdata;

  modport bus (output wr, output addr, output wdata, output sel, input rdata);
  modport regs (input wr, input addr, input wdata, input sel, output rdata);
endinterface

// ### design/erc_wb_slave.sv
// Classic Wishbone slave front end: one wait state, registered read data.
// Assumes a master that holds its request until it samples ack.
`timescale 1ns/1ps

module erc_wb_slave (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel,
  output logic ack,
  output logic [31:0] dat_o,
  erc_acc_if.bus acc
);

  assign acc.addr = adr;
  assign acc.wdata = dat_i;
  assign acc.sel = sel;
  // The write lands on the edge where the master sees ack, never earlier.
  assign acc.wr = ce & cyc & stb & we & ack;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= cyc & stb & ~ack;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dat_o <= 32'h0000_0000;
    end else if (ce && cyc && stb && !ack && !we) begin
      dat_o <= acc.rdata;
    end
  end

  // ==========================================================================
  // Checks
  a_ack_single: assert property (@(posedge clk) disable iff (!nrst)
    (ce && ack) |=> !ack) else $error("ack held longer than one cycle");
  a_ack_answers: assert property (@(posedge clk) disable iff (!nrst)
    (ce && cyc && stb && !ack) |=> ack) else $error("request not answered next cycle");

endmodule

// ### design/erc_comp.sv
// Error status engine of one protocol component.
// Assumes error events are one-cycle strobes from logic on the same clock.
`timescale 1ns/1ps

module erc_comp (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic dev_en,
  input wire logic [1:0] dis,
  input wire logic [erc_pkg::NCLASS-1:0] class_mask,
  input wire logic [erc_pkg::NSEV-1:0] msg_mask,
  input wire logic [erc_pkg::NSEV-1:0] cap_mask,
  input wire logic err_valid,
  input wire logic [erc_pkg::CLASS_IDX_W-1:0] err_class,
  input wire logic [erc_pkg::SEV_W-1:0] err_sev,
  input wire logic sta_clear,
  output erc_pkg::erc_sta_t sta,
  output logic log_capture,
  output logic msg_send,
  output logic log_clear
);

  logic [15:0] class_ext;
  logic [7:0] msg_ext;
  logic [7:0] cap_ext;
  logic accepted;
  logic want_log;
  logic want_msg;
  logic free;
  logic take;
  erc_pkg::erc_sta_t next_sta;

  assign class_ext = {6'h00, class_mask};
  assign msg_ext = {1'b0, msg_mask};
  assign cap_ext = {1'b0, cap_mask};
  assign accepted = err_valid & dev_en & ~class_ext[err_class];
  assign want_log = accepted & ~dis[erc_pkg::DIS_LOG_POS] & ~cap_ext[err_sev];
  assign want_msg = accepted & ~dis[erc_pkg::DIS_MSG_POS] & ~msg_ext[err_sev];
  // A clear in the same cycle frees the log, so the new error is not lost.
  assign free = (sta == erc_pkg::STA_CLEAR) | sta_clear;
  assign take = want_log & free;

  always_comb begin
    next_sta = sta;
    if (take) begin
      next_sta = want_msg ? erc_pkg::STA_REPORTED : erc_pkg::STA_LOGGED;
    end else if (sta_clear) begin
      next_sta = erc_pkg::STA_CLEAR;
    end
  end

  // Device enable never touches the status; pending errors survive it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sta <= erc_pkg::STA_CLEAR;
    end else if (ce) begin
      sta <= next_sta;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      log_capture <= 1'b0;
      msg_send <= 1'b0;
      log_clear <= 1'b0;
    end else if (ce) begin
      log_capture <= take;
      msg_send <= take & want_msg;
      log_clear <= sta_clear;
    end
  end

  // ==========================================================================
  // Checks
  a_clear_to_zero: assert property (@(posedge clk) disable iff (!nrst)
    (ce && sta_clear && !err_valid) |=> (sta == erc_pkg::STA_CLEAR) && log_clear)
    else $error("status not cleared by ones write");
  a_new_log_code: assert property (@(posedge clk) disable iff (!nrst)
    (ce && want_log && sta == erc_pkg::STA_CLEAR) |=>
      (sta == ($past(want_msg) ? erc_pkg::STA_REPORTED : erc_pkg::STA_LOGGED)) && log_capture)
    else $error("wrong status after new log");
  a_no_overwrite: assert property (@(posedge clk) disable iff (!nrst)
    (ce && sta != erc_pkg::STA_CLEAR && !sta_clear) |=> !log_capture && $stable(sta))
    else $error("log overwritten while pending");
  a_never_invalid: assert property (@(posedge clk) disable iff (!nrst)
    sta != erc_pkg::STA_INVALID) else $error("status holds invalid code");
  a_msg_gated: assert property (@(posedge clk) disable iff (!nrst)
    (ce && (!dev_en || dis[erc_pkg::DIS_MSG_POS])) |=> !msg_send)
    else $error("message sent while disabled");
  a_pending_kept: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !dev_en && !sta_clear) |=> $stable(sta)) else $error("status moved while disabled");
  a_class_masked: assert property (@(posedge clk) disable iff (!nrst)
    (ce && err_valid && class_ext[err_class]) |=> !log_capture && !msg_send)
    else $error("masked class logged");

  c_reported: cover property (@(posedge clk) disable iff (!nrst)
    ce && take && want_msg);
  c_logged_only: cover property (@(posedge clk) disable iff (!nrst)
    ce && take && !want_msg);
  c_clear_and_set: cover property (@(posedge clk) disable iff (!nrst)
    ce && take && sta_clear && sta != erc_pkg::STA_CLEAR);

endmodule

// ### dv/error_report_control_test.sv
// Self-checking bench for the error report control register bank.
// Assumes the design package, interface and modules under design/ are compiled first.
`timescale 1ns/1ps

module error_report_control_test;
  `define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    fail_count++; $display("unexpected %s expected %h seen %h", nm, exp, got); end end

  typedef struct {
    logic [7:0] adr;
    logic [31:0] exp;
  } erc_row_t;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic ack;
  logic [31:0] rdat;
  logic [4:0] err_valid = 5'h00;
  logic [19:0] err_class = 20'h00000;
  logic [14:0] err_sev = 15'h0000;
  logic [4:0] log_capture;
  logic [4:0] msg_send;
  logic [4:0] log_clear;
  logic [4:0] clr_seen = 5'h00;
  logic dev_enable;
  logic [31:0] rd;
  int fail_count = 0;
  int samples_checked = 0;
  // Reset image: device enable, then status/control and mask of each component.
  erc_row_t rows [12] = '{'{8'h00, 32'h0}, '{8'h10, 32'hC}, '{8'h14, 32'h0},
    '{8'h18, 32'hC}, '{8'h1C, 32'h0}, '{8'h20, 32'hC}, '{8'h24, 32'h0},
    '{8'h28, 32'hC}, '{8'h2C, 32'h0}, '{8'h30, 32'hC}, '{8'h34, 32'h0}, '{8'hF0, 32'h0}};

  erc_top u_dut (
    .CLK(clk),
    .NRST(nrst),
    .CE(ce),
    .WB_CYC_I(cyc),
    .WB_STB_I(stb),
    .WB_WE_I(we),
    .WB_ADR_I(adr),
    .WB_DAT_I(wdat),
    .WB_SEL_I(sel),
    .WB_ACK_O(ack),
    .WB_DAT_O(rdat),
    .ERR_VALID(err_valid),
    .ERR_CLASS(err_class),
    .ERR_SEV(err_sev),
    .LOG_CAPTURE(log_capture),
    .MSG_SEND(msg_send),
    .LOG_CLEAR(log_clear),
    .DEV_ENABLE(dev_enable)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // The clear pulse is collected here so its exact cycle does not matter to the bench.
  always @(posedge clk) begin
    clr_seen <= clr_seen | log_clear;
  end

  // ==========================================================================
  // Tasks
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) begin
        break;
      end
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // A write lands on the ack edge itself, so callers look at outputs just after it.
    #1;
    if (n == 20) begin
      fail_count++;
      results();
    end
  endtask

  // One error strobe; exp holds the expected message and capture pulses.
  task automatic err(input int i, input logic [3:0] cls, input logic [2:0] sev,
                     input logic [1:0] exp);
    @(posedge clk);
    err_valid[i] <= 1'b1;
    err_class[4*i +: 4] <= cls;
    err_sev[3*i +: 3] <= sev;
    @(posedge clk);
    err_valid <= 5'h00;
    #1;
    `CHK("msg_capture", exp, {msg_send[i], log_capture[i]});
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    `CHK("dev_enable", 1'b0, dev_enable);
    foreach (rows[k]) begin
      wb(1'b0, rows[k].adr, 32'h0, rd);
      `CHK("reset_value", rows[k].exp, rd);
    end
    wb(1'b1, 8'hF0, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'hF0, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd);
    wb(1'b1, 8'h10, 32'h0, rd);
    err(0, 4'h0, 3'h0, 2'b00);
    wb(1'b1, 8'h00, 32'h1, rd);
    `CHK("dev_enable", 1'b1, dev_enable);
    wb(1'b1, 8'h10, 32'hC, rd);
    err(0, 4'h0, 3'h0, 2'b00);
    wb(1'b1, 8'h10, 32'h0, rd);
    err(0, 4'h5, 3'h0, 2'b11);
    wb(1'b0, 8'h10, 32'h0, rd);
    `CHK("status0", 32'h3, rd);
    err(0, 4'h0, 3'h0, 2'b00);
    wb(1'b1, 8'h10, 32'h0, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    `CHK("status0", 32'h3, rd);
    `CHK("log_clear", 1'b0, clr_seen[0]);
    wb(1'b1, 8'h10, 32'h3, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    `CHK("status0", 32'h0, rd);
    `CHK("log_clear", 1'b1, clr_seen[0]);
    err(0, 4'h1, 3'h0, 2'b11);
    wb(1'b1, 8'h18, 32'h8, rd);
    err(1, 4'h0, 3'h0, 2'b01);
    wb(1'b0, 8'h18, 32'h0, rd);
    `CHK("status1", 32'h9, rd);
    wb(1'b1, 8'h20, 32'h0, rd);
    wb(1'b1, 8'h24, 32'h00040000, rd);
    err(2, 4'h2, 3'h0, 2'b00);
    err(2, 4'h3, 3'h0, 2'b11);
    wb(1'b1, 8'h28, 32'h0, rd);
    wb(1'b1, 8'h2C, 32'h00000002, rd);
    err(3, 4'h0, 3'h1, 2'b00);
    wb(1'b1, 8'h30, 32'h0, rd);
    wb(1'b1, 8'h34, 32'h00000080, rd);
    err(4, 4'h0, 3'h0, 2'b01);
    wb(1'b1, 8'h00, 32'h0, rd);
    `CHK("dev_enable", 1'b0, dev_enable);
    wb(1'b0, 8'h18, 32'h0, rd);
    `CHK("status1", 32'h9, rd);
    err(3, 4'h0, 3'h0, 2'b00);
    // Log disabled alone must also silence the message, which only rides on a capture.
    wb(1'b1, 8'h00, 32'h1, rd);
    wb(1'b1, 8'h28, 32'h4, rd);
    err(3, 4'h0, 3'h0, 2'b00);
    wb(1'b1, 8'h28, 32'h0, rd);
    // With the clock enable low the strobe is not even seen.
    @(posedge clk);
    ce <= 1'b0;
    err(3, 4'h0, 3'h0, 2'b00);
    @(posedge clk);
    ce <= 1'b1;
    err(3, 4'h0, 3'h0, 2'b11);
    wb(1'b0, 8'h28, 32'h0, rd);
    `CHK("status3", 32'h3, rd);
    // A reset in mid-run must drop the pending error and every enable.
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    `CHK("dev_enable", 1'b0, dev_enable);
    wb(1'b0, 8'h28, 32'h0, rd);
    `CHK("status3", 32'hC, rd);
    wb(1'b0, 8'h00, 32'h0, rd);
    `CHK("dev_reg", 32'h0, rd);
    results();
  end
endmodule
